// ### spi_shift_pkg.sv
// Purpose: Shared constants and types of the serial shifter.
// Assumes: System clock of 100 MHz.
// Notes: Serial clock rate in master mode is set by the period below.
package spi_shift_pkg;
	localparam int SYS_CLK_MHZ = 100;
	localparam int SCK_PERIOD_NS = 80;
	localparam int HALF_CNT = (SCK_PERIOD_NS * SYS_CLK_MHZ + 1999) / 2000;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_RISE = DIV_W'(HALF_CNT - 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(2 * HALF_CNT - 1);
	localparam int SYNC_STAGES = 2;
	localparam logic [DIV_W-1:0] DIV_SAMPLE =
		DIV_W'(HALF_CNT - 1 + SYNC_STAGES);
	localparam int WORD_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int FIFO_DEPTH = 16;
	localparam logic [WORD_W-1:0] FILLER_BYTE = 8'h00;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE = 2'b10
	} mst_state_t;
endpackage : spi_shift_pkg

// ### link_xfer_if.sv
// Purpose: Word handshake between the core and the link-clocked slave end.
// Assumes: Requests and completions are toggles; words stay stable meanwhile.
// Notes: Core side runs on clk, link side on the serial clock.
`timescale 1ns/1ns
`default_nettype none
interface link_xfer_if;
	logic [7:0] tx_word;
	logic tx_req;
	logic tx_ack;
	logic [7:0] rx_word;
	logic rx_tgl;
	modport core (output tx_word, output tx_req,
		input tx_ack, input rx_word, input rx_tgl);
	modport link (input tx_word, input tx_req,
		output tx_ack, output rx_word, output rx_tgl);
endinterface : link_xfer_if
`default_nettype wire

// ### byte_fifo.sv
// Purpose: Receive buffer with valid/ready on both sides.
// Assumes: Single clock, synchronous reset.
// Notes: Depth must be a power of two.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_t;
	fifo_t cur, next_cur;
	logic push, pop;
	assign in_ready = (cur.count != (AW+1)'(DEPTH));
	assign out_valid = (cur.count != '0);
	assign out_data = cur.mem[cur.rd];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_comb begin
		next_cur = cur;
		if (push) begin
			next_cur.mem[cur.wr] = in_data;
			next_cur.wr = cur.wr + 1'b1;
		end
		if (pop)
			next_cur.rd = cur.rd + 1'b1;
		if (push && !pop)
			next_cur.count = cur.count + 1'b1;
		else if (pop && !push)
			next_cur.count = cur.count - 1'b1;
	end
	always_ff @(posedge clk) begin
		if (srst)
			cur <= '0;
		else
			cur <= next_cur;
	end
endmodule : byte_fifo
`default_nettype wire

// ### spi_slave_link.sv
// Purpose: Slave end of the serial link, clocked by the incoming serial clock.
// Assumes: Mode 0 framing; no select line, so bytes are counted as 8 clocks.
// Notes: Reset reaches this domain only while the serial clock runs.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_link
	import spi_shift_pkg::*;
(
	// Link clock and reset request from the core domain
	input wire logic link_clk,
	input wire logic srst,
	// Serial pins seen by the slave
	input wire logic mosi_i,
	output logic miso_q,
	// Word exchange with the core
	link_xfer_if.link xfer
);
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic req_s1;
		logic req_s2;
		logic ack;
		logic [2:0] cnt;
		logic [7:0] shift;
		logic [7:0] rx_word;
		logic rx_tgl;
	} slv_t;
	slv_t cur, next_cur;
	assign xfer.tx_ack = cur.ack;
	assign xfer.rx_word = cur.rx_word;
	assign xfer.rx_tgl = cur.rx_tgl;
	always_comb begin
		next_cur = cur;
		next_cur.rst_s1 = srst;
		next_cur.rst_s2 = cur.rst_s1;
		next_cur.req_s1 = xfer.tx_req;
		next_cur.req_s2 = cur.req_s1;
		if (cur.rst_s2) begin
			// Toggles start level with the core so no false byte or ack
			next_cur.cnt = '0;
			next_cur.shift = FILLER_BYTE;
			next_cur.ack = 1'b0;
			next_cur.rx_word = '0;
			next_cur.rx_tgl = 1'b0;
		end else if (cur.cnt == LAST_BIT) begin
			// Byte complete: hand it over and load the next reply
			next_cur.rx_word = {cur.shift[6:0], mosi_i};
			next_cur.rx_tgl = ~cur.rx_tgl;
			next_cur.cnt = '0;
			if (cur.req_s2 != cur.ack) begin
				next_cur.shift = xfer.tx_word;
				next_cur.ack = ~cur.ack;
			end else begin
				next_cur.shift = FILLER_BYTE;
			end
		end else begin
			next_cur.shift = {cur.shift[6:0], mosi_i};
			next_cur.cnt = cur.cnt + 3'h1;
		end
	end
	always_ff @(posedge link_clk) begin
		cur <= next_cur;
	end
	// Reply bit launched on the falling edge, sampled on the rising one
	always_ff @(negedge link_clk) begin
		if (cur.rst_s2)
			miso_q <= 1'b0;
		else
			miso_q <= cur.shift[7];
	end
endmodule : spi_slave_link
`default_nettype wire

// ### spi_master_slave_shifter.sv
// Purpose: Byte shifter for a three-wire serial link, master or slave.
// Assumes: clk at 100 MHz; in slave mode the serial clock is link_clk.
// Notes: Received bytes pass through a 16-word buffer to the user.
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_shifter
	import spi_shift_pkg::*;
(
	// System clock and reset
	input wire logic clk,
	input wire logic srst,
	// Serial clock from the far master, used in slave mode
	input wire logic link_clk,
	// Role select, taken while idle
	input wire logic master_mode,
	// Bytes to send
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_discard,
	// Read request: master sends a filler byte
	input wire logic read_req,
	output logic read_ready,
	// Received bytes
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	// Status
	output logic busy,
	output logic rx_overrun,
	input wire logic overrun_clr,
	// Serial clock pin
	output logic sck_o,
	output logic sck_oe,
	// Master-out data pin
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	// Master-in data pin
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe
);
	typedef struct packed {
		mst_state_t st;
		logic master;
		logic sck;
		logic mosi;
		logic [7:0] tx_shift;
		logic [7:0] rx_shift;
		logic [2:0] bit_idx;
		logic [DIV_W-1:0] div;
		logic discard;
		logic miso_s1;
		logic miso_s2;
		logic ack_s1;
		logic ack_s2;
		logic rxt_s1;
		logic rxt_s2;
		logic rxt_s3;
		logic slave_req;
		logic [7:0] slave_word;
		logic [7:0] cap_word;
		logic cap_valid;
		logic overrun;
	} core_t;

	core_t cur, next_cur;

	link_xfer_if xfer ();

	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic slave_pending;
	logic slave_byte_done;
	logic mst_idle;
	logic mst_take_tx;
	logic mst_take_read;
	logic slv_take_tx;
	logic miso_link;

	// Slave end on the far master's clock
	spi_slave_link u_slave (
		.link_clk(link_clk),
		.srst(srst),
		.mosi_i(mosi_i),
		.miso_q(miso_link),
		.xfer(xfer)
	);

	// Received byte buffer; a full buffer stalls the master
	byte_fifo #(
		.W(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// Word handshake towards the slave end
	assign xfer.tx_word = cur.slave_word;
	assign xfer.tx_req = cur.slave_req;

	assign slave_pending = (cur.slave_req != cur.ack_s2);
	assign slave_byte_done = cur.rxt_s2 ^ cur.rxt_s3;

	// Master accepts new work only when idle
	assign mst_idle = (cur.st == ST_IDLE) && master_mode;
	assign mst_take_tx = mst_idle && tx_valid;
	assign mst_take_read = mst_idle && !tx_valid && read_req;
	assign slv_take_tx = !master_mode && (cur.st == ST_IDLE) &&
		!slave_pending && tx_valid;

	// Handshake outputs
	assign tx_ready = (cur.st == ST_IDLE) &&
		(master_mode || !slave_pending);
	assign read_ready = mst_idle && !tx_valid;
	assign busy = (cur.st != ST_IDLE) || slave_pending;

	// Buffer feed: master result or slave capture, by role
	always_comb begin
		if (cur.master) begin
			fifo_in_valid = (cur.st == ST_DONE) && !cur.discard;
			fifo_in_data = cur.rx_shift;
		end else begin
			fifo_in_valid = cur.cap_valid;
			fifo_in_data = cur.cap_word;
		end
	end

	// Pin drivers
	assign sck_o = cur.sck;
	assign sck_oe = cur.master;
	assign mosi_o = cur.mosi;
	assign mosi_oe = cur.master;
	assign miso_o = miso_link;
	assign miso_oe = !cur.master;
	assign rx_overrun = cur.overrun;

	always_comb begin
		next_cur = cur;

		// Pin and toggle synchronisers
		next_cur.miso_s1 = miso_i;
		next_cur.miso_s2 = cur.miso_s1;
		next_cur.ack_s1 = xfer.tx_ack;
		next_cur.ack_s2 = cur.ack_s1;
		next_cur.rxt_s1 = xfer.rx_tgl;
		next_cur.rxt_s2 = cur.rxt_s1;
		next_cur.rxt_s3 = cur.rxt_s2;

		case (cur.st)
			ST_IDLE: begin
				next_cur.sck = 1'b0;
				next_cur.master = master_mode;
				next_cur.div = '0;
				next_cur.bit_idx = '0;
				if (mst_take_tx) begin
					next_cur.tx_shift = tx_data;
					next_cur.mosi = tx_data[7];
					next_cur.discard = tx_discard;
					next_cur.st = ST_SHIFT;
				end else if (mst_take_read) begin
					// Filler keeps the clock running for the reply
					next_cur.tx_shift = FILLER_BYTE;
					next_cur.mosi = FILLER_BYTE[7];
					next_cur.discard = 1'b0;
					next_cur.st = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				next_cur.div = cur.div + 1'b1;
				if (cur.div == DIV_RISE)
					next_cur.sck = 1'b1;
				// Rising-edge value, seen after the synchroniser delay
				if (cur.div == DIV_SAMPLE)
					next_cur.rx_shift =
						{cur.rx_shift[6:0], cur.miso_s2};
				if (cur.div == DIV_LAST) begin
					next_cur.sck = 1'b0;
					next_cur.div = '0;
					if (cur.bit_idx == LAST_BIT) begin
						next_cur.st = ST_DONE;
					end else begin
						// Next bit launched on the falling edge
						next_cur.bit_idx = cur.bit_idx + 3'h1;
						next_cur.tx_shift = {cur.tx_shift[6:0], 1'b0};
						next_cur.mosi = cur.tx_shift[6];
					end
				end
			end
			ST_DONE: begin
				// Wait for buffer room unless the byte is dropped
				if (cur.discard || fifo_in_ready)
					next_cur.st = ST_IDLE;
			end
			default: begin
				next_cur.st = ST_IDLE;
			end
		endcase

		// Slave role: stage the next reply byte for the link end
		if (slv_take_tx) begin
			next_cur.slave_word = tx_data;
			next_cur.slave_req = ~cur.slave_req;
		end

		// Slave role: capture completed bytes from the link end
		if (fifo_in_ready && !cur.master)
			next_cur.cap_valid = 1'b0;
		if (slave_byte_done && !cur.master) begin
			next_cur.cap_word = xfer.rx_word;
			next_cur.cap_valid = 1'b1;
		end

		// Lost byte flag; a new loss beats a clear
		if (overrun_clr)
			next_cur.overrun = 1'b0;
		if (slave_byte_done && !cur.master && cur.cap_valid &&
			!fifo_in_ready)
			next_cur.overrun = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule : spi_master_slave_shifter
`default_nettype wire

// ### spi_shifter_asserts.sv
// Purpose: Port checks of the serial byte shifter.
// Assumes: Bound to the top module; clk domain only.
// Notes: Serial words on the wire are judged by the bench.
`timescale 1ns/1ns
`default_nettype none
module spi_shifter_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// User side
	input wire logic master_mode,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_discard,
	input wire logic read_req,
	input wire logic read_ready,
	input wire logic rx_valid,
	input wire logic busy,
	// Pins
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic mosi_o,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Serial clock pulses seen within one busy spell
	logic [3:0] rises;
	always_ff @(posedge clk) begin
		if (srst || !busy) begin
			rises <= 4'h0;
		end else if ($rose(sck_o)) begin
			rises <= rises + 4'h1;
		end
	end
	sequence s_read_take;
		read_req && read_ready && sck_oe && !rx_valid;
	endsequence
	sequence s_drop_take;
		tx_valid && tx_ready && tx_discard && sck_oe && !rx_valid;
	endsequence
	a_role_pins: assert property (sck_oe == mosi_oe
		&& mosi_oe != miso_oe) else $error("pin enables off role");
	a_role_follow: assert property (!busy
		|=> sck_oe == $past(master_mode)) else $error("role not taken");
	a_sck_idle: assert property (!busy |-> !sck_o)
		else $error("serial clock moved while idle");
	a_mosi_launch: assert property ($changed(mosi_o) |-> !sck_o)
		else $error("data changed while clock high");
	a_sck_high: assert property ($rose(sck_o)
		|-> sck_o[*4] ##1 !sck_o) else $error("clock high time wrong");
	a_eight_pulses: assert property ($fell(busy) && sck_oe
		|-> rises == 4'h8) else $error("pulse count not eight");
	a_busy_refuse: assert property (busy |-> !tx_ready)
		else $error("byte taken while busy");
	a_read_clocks: assert property (read_req && read_ready
		|-> ##5 sck_o) else $error("filler read gave no clock");
	a_read_reply: assert property (s_read_take
		|-> ##[64:68] rx_valid) else $error("reply byte late");
	a_drop_rx: assert property (s_drop_take |-> ##67 !rx_valid)
		else $error("dropped byte was kept");
endmodule : spi_shifter_asserts
bind spi_master_slave_shifter spi_shifter_asserts chk (.*);
`default_nettype wire

// ### spi_far_slave.sv
// Purpose: Far slave on the serial link for master-mode runs.
// Assumes: Clock idles low; launch on falling, sample on rising.
// Notes: Reply byte is held by the bench across a transfer.
`timescale 1ns/1ns
`default_nettype none
module spi_far_slave (
	// Serial pins
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// Bench side
	input wire logic [7:0] reply,
	output logic [7:0] got
);
	logic [2:0] pos = 3'h0;
	logic [2:0] rises = 3'h0;
	initial got = 8'h00;
	assign miso = reply[3'h7 - pos];
	always @(posedge sck) begin
		got <= {got[6:0], mosi};
		rises <= rises + 3'h1;
	end
	// Bit index follows counted rises, so a power-up fall moves nothing
	always @(negedge sck) begin
		pos <= rises;
	end
endmodule : spi_far_slave
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench of the serial byte shifter.
// Assumes: Far slave model in master mode; bench clocks in slave mode.
// Notes: Reset is stretched so the link end sees clock edges.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import spi_shift_pkg::*;
();
	logic clk, srst, lclk, master_mode, tx_valid, tx_discard;
	logic read_req, rx_ready, overrun_clr, tb_mosi;
	logic [7:0] tx_data, reply, far_got, rx_data;
	logic tx_ready, read_ready, rx_valid, busy, rx_overrun, far_miso;
	logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	wire logic mosi_w, miso_w, far_sck;
	int num_errors = 0;
	int comparisons = 0;
	assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
	assign miso_w = miso_oe ? miso_o : far_miso;
	assign far_sck = sck_oe & sck_o;
	spi_master_slave_shifter dut (.*, .link_clk(lclk),
		.mosi_i(mosi_w), .miso_i(miso_w));
	spi_far_slave far (.sck(far_sck), .mosi(mosi_w), .miso(far_miso),
		.reply(reply), .got(far_got));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic await(input bit on_rx);
		int n;
		for (n = 0; n < 300; n++) begin
			if (on_rx ? rx_valid === 1'b1 : busy === 1'b0) break;
			tick(1);
		end
		if (n == 300) begin
			check(8'h00, 8'h01);
			results;
		end
	endtask : await
	task automatic pop;
		tick(1);
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
	endtask : pop
	task automatic take(input logic [7:0] b, input logic drop);
		await(0);
		tx_data = b;
		tx_discard = drop;
		tx_valid = 1'b1;
		tick(1);
		tx_valid = 1'b0;
		tx_discard = 1'b0;
	endtask : take
	task automatic t_send;
		reply = 8'h3c;
		take(8'ha5, 1'b1);
		await(0);
		check(far_got, 8'ha5);
		tick(3);
		check({7'h00, rx_valid}, 8'h00);
		reply = 8'hc3;
		take(8'h5a, 1'b0);
		await(1);
		check(far_got, 8'h5a);
		check(rx_data, 8'hc3);
		pop;
	endtask : t_send
	task automatic t_fill;
		int i;
		for (i = 0; i <= FIFO_DEPTH; i++) begin
			await(0);
			reply = 8'h40 + 8'(i);
			read_req = 1'b1;
			tick(1);
			read_req = 1'b0;
			tick(70);
			check(far_got, FILLER_BYTE);
		end
		check({7'h00, busy}, 8'h01);
		for (i = 0; i <= FIFO_DEPTH; i++) begin
			await(1);
			check(rx_data, 8'h40 + 8'(i));
			pop;
		end
	endtask : t_fill
	task automatic clock_byte(input logic [7:0] b, output logic [7:0] seen);
		int i;
		for (i = 7; i >= 0; i--) begin
			tb_mosi = b[i];
			#80 lclk = 1'b1;
			seen[i] = miso_w;
			#80 lclk = 1'b0;
		end
	endtask : clock_byte
	task automatic frame(input logic [7:0] b, input logic [7:0] exp);
		logic [7:0] seen;
		clock_byte(b, seen);
		tb_mosi = ~tb_mosi;
		check(seen, exp);
		await(1);
		check(rx_data, b);
		pop;
	endtask : frame
	task automatic t_slave;
		master_mode = 1'b0;
		tick(2);
		take(8'h6b, 1'b0);
		frame(8'h96, 8'h00);
		frame(8'h69, 8'h6b);
	endtask : t_slave
	task automatic t_overrun;
		logic [7:0] seen;
		int j;
		// Two bytes past a full buffer: the last one replaces the held one
		for (j = 0; j < FIFO_DEPTH + 2; j++) begin
			clock_byte(8'h10 + 8'(j), seen);
			check(seen, FILLER_BYTE);
		end
		tick(2);
		check({7'h00, rx_overrun}, 8'h01);
		overrun_clr = 1'b1;
		tick(1);
		overrun_clr = 1'b0;
		check({7'h00, rx_overrun}, 8'h00);
		for (j = 0; j <= FIFO_DEPTH; j++) begin
			await(1);
			check(rx_data, (j < FIFO_DEPTH) ? 8'h10 + 8'(j) : 8'h21);
			pop;
		end
	endtask : t_overrun
	initial begin
		srst = 1'b1;
		lclk = 1'b0;
		master_mode = 1'b1;
		tx_valid = 1'b0;
		tx_discard = 1'b0;
		read_req = 1'b0;
		rx_ready = 1'b0;
		overrun_clr = 1'b0;
		tb_mosi = 1'b0;
		tx_data = 8'h00;
		reply = 8'h00;
		// Link end needs edges in reset and two more to leave it
		repeat (6) #80 lclk = ~lclk;
		tick(1);
		srst = 1'b0;
		repeat (4) #80 lclk = ~lclk;
		tick(2);
		t_send;
		t_fill;
		t_slave;
		t_overrun;
		results;
	end
endmodule : tb_top
`default_nettype wire
